// >>> pkg/i2c_master_pkg.sv
// Constants, widths and state codes shared by the byte engine files
package i2c_master_pkg;

  // Data path and counter widths
  localparam int DATA_W   = 8;
  localparam int BRG_W    = 7;
  localparam int CNT_W    = 4;
  localparam int RX_DEPTH = 2;

  // Bit counter landmarks within one nine-clock byte frame
  localparam logic [CNT_W-1:0] BIT_FIRST = 4'h0;
  localparam logic [CNT_W-1:0] BIT_LAST  = 4'h7;
  localparam logic [CNT_W-1:0] BIT_ACK   = 4'h8;
  localparam logic [CNT_W-1:0] BIT_STEP  = 4'h1;

  // Baud counter landmarks
  localparam logic [BRG_W-1:0] BRG_ZERO = 7'h00;
  localparam logic [BRG_W-1:0] BRG_STEP = 7'h01;

  // Reset values
  localparam logic [DATA_W-1:0] SHIFT_RST = 8'h00;
  localparam logic              FLAG_RST  = 1'b0;

  // Engine states, Gray coded along transmit, receive, acknowledge, stop
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_TX_LO = 4'h1,
    ST_TX_HI = 4'h3,
    ST_RX_LO = 4'h2,
    ST_RX_HI = 4'h6,
    ST_AK_LO = 4'h7,
    ST_AK_HI = 4'h5,
    ST_SP_LO = 4'h4,
    ST_SP_CK = 4'hC,
    ST_SP_DA = 4'hD,
    ST_SP_END = 4'hF
  } state_e;

endpackage

// >>> rtl/i2c_master_byte_engine.sv
// I2C master byte engine: transmit, receive, acknowledge and stop sequencing
// Function
// - Buffer write during sequence sets collision
// - Control sets ignored while repeated start busy
// - Buffer write sets full, starts counter
// - Bit driven after SCL falls, equal halves
// - Eighth fall clears full, releases SDA
// - Ninth fall samples SDA into ack status
// - After ninth: interrupt, counter stops, SCL low
// - Seven address bits plus direction, MSB first
// - Full set by write, cleared after eight
// - Write while shifting: collision, write discarded
// - Receive enable only honoured after acknowledge
// - Receive: rollovers toggle SCL, shift in SDA
// - Eighth receive fall: store byte, interrupt, idle
// - CPU read that empties the buffer clears full
// - Byte completes while full sets overflow
// - Acknowledge sequence drives data bit, one clock
// - Stop: SDA low, SCL release, SDA release
// - Stop seen sets flag, later interrupt
// - Keeps working asleep, wakes on interrupt when portIntEnable set
// - Reset or disable aborts, clears detections
// - Bus free tracking, stop interrupt when busy and portIntEnable set
// - Released SDA read low on data bits or ack sequence sets collision
// - Counter reloads seven bits, counts to zero
// - Counter waits for SCL high after release
`timescale 1ns/1ps
module i2c_master_byte_engine (
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Configuration and control
  input  wire logic       moduleEnable,
  input  wire logic       sleepMode,
  input  wire logic       portIntEnable,
  input  wire logic [6:0] reloadValue,
  input  wire logic       ackDataBit,
  input  wire logic       repeatedStartBusy,
  input  wire logic       ackSeqSet,
  input  wire logic       stopSeqSet,
  input  wire logic       rcvEnSet,
  input  wire logic       wcolClr,
  input  wire logic       ovClr,
  input  wire logic       intClr,
  input  wire logic       bclClr,
  // Buffer access
  input  wire logic       bufWrite,
  input  wire logic [7:0] bufWrData,
  input  wire logic       bufRead,
  output logic      [7:0] bufRdData,
  output logic            bufRdValid,
  // Bus pins
  input  wire logic       sdaPin,
  input  wire logic       sclPin,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic            sclOut,
  output logic            sclOe,
  // Status
  output logic            bufferFullFlag,
  output logic            writeCollisionFlag,
  output logic            ackStatusFlag,
  output logic            receiveEnableBit,
  output logic            ackSequenceEnable,
  output logic            stopSequenceEnable,
  output logic            portInterruptFlag,
  output logic            receiveOverflowFlag,
  output logic            busCollisionFlag,
  output logic            startSeen,
  output logic            stopSeen,
  output logic            busFree,
  output logic            wakeUp,
  output logic            engineIdle
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  i2c_master_pkg::state_e state_r, state_nxt;

  logic [i2c_master_pkg::DATA_W-1:0] shift_r, shift_nxt;
  logic [i2c_master_pkg::CNT_W-1:0]  bitCnt_r, bitCnt_nxt;
  logic [i2c_master_pkg::BRG_W-1:0]  brgCnt_r;
  logic sdaLow_r, sdaLow_nxt;
  logic sclLow_r, sclLow_nxt;
  logic txFull_r, txFull_nxt;
  logic afterAck_r, afterAck_nxt;
  logic ack_status_flag_r, ack_status_flag_nxt;
  logic rcvEn_r, rcvEn_nxt;
  logic ack_sequence_enable_r, ack_sequence_enable_nxt;
  logic stopEn_r, stopEn_nxt;
  logic write_collision_flag_r, int_r, ov_r, bcl_r;
  logic startSeen_r, stopSeen_r;
  logic sdaPrev_r, sclPrev_r;
  logic brgLoad;
  logic setInt, setOv, setBcl, rxPush;
  logic [1:0] pinsSync;
  logic rxInReady;

  wire sdaIn = pinsSync[1];
  wire sclIn = pinsSync[0];
  wire brgDone = (brgCnt_r == i2c_master_pkg::BRG_ZERO);
  wire isIdle = (state_r == i2c_master_pkg::ST_IDLE);
  wire [7:0] rxByte = {shift_r[6:0], sdaIn};

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and bus condition detection

  // Both pin levels pass two flip-flops before use
  pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .pinAsync ({sdaPin, sclPin}),
    .pinSync  (pinsSync)
  );

  // Previous synchronised levels for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sdaPrev_r <= 1'b1;
      sclPrev_r <= 1'b1;
    end else begin
      sdaPrev_r <= sdaIn;
      sclPrev_r <= sclIn;
    end
  end

  // START is SDA falling with SCL high, STOP is SDA rising with SCL high
  wire startDet = sclIn && sclPrev_r && sdaPrev_r && !sdaIn;
  wire stopDet  = sclIn && sclPrev_r && !sdaPrev_r && sdaIn;

  ////////////////////////////////////////////////////////////////////////////
  // Request qualification

  // Control sets only taken when idle and no repeated start pending
  wire ctrlOk = isIdle && !repeatedStartBusy && moduleEnable;
  // Any enabled buffer write the engine cannot take (not idle, or repeated start pending) collides and is dropped
  wire wrColl = bufWrite && moduleEnable && !ctrlOk;
  wire wrTake = bufWrite && ctrlOk;
  // Arbitration: released SDA read back low while SCL high
  wire txLost = sclIn && !sdaLow_r && !sdaIn
                && (bitCnt_r != i2c_master_pkg::BIT_ACK);
  wire akLost = sclIn && !sdaLow_r && !sdaIn;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next state, pin drive and events
  always_comb begin
    state_nxt    = state_r;
    shift_nxt    = shift_r;
    bitCnt_nxt   = bitCnt_r;
    sdaLow_nxt   = sdaLow_r;
    sclLow_nxt   = sclLow_r;
    txFull_nxt   = txFull_r;
    afterAck_nxt = afterAck_r;
    ack_status_flag_nxt  = ack_status_flag_r;
    rcvEn_nxt    = rcvEn_r;
    ack_sequence_enable_nxt    = ack_sequence_enable_r;
    stopEn_nxt   = stopEn_r;
    brgLoad      = 1'b0;
    setInt       = 1'b0;
    setOv        = 1'b0;
    setBcl       = 1'b0;
    rxPush       = 1'b0;
    unique case (state_r)
      i2c_master_pkg::ST_IDLE: begin
        if (wrTake) begin
          shift_nxt  = bufWrData;
          txFull_nxt = 1'b1;
          bitCnt_nxt = i2c_master_pkg::BIT_FIRST;
          sclLow_nxt = 1'b1;
          sdaLow_nxt = !bufWrData[7];
          brgLoad    = 1'b1;
          state_nxt  = i2c_master_pkg::ST_TX_LO;
        end else if (ackSeqSet && ctrlOk) begin
          ack_sequence_enable_nxt  = 1'b1;
          sclLow_nxt = 1'b1;
          sdaLow_nxt = !ackDataBit;
          brgLoad    = 1'b1;
          state_nxt  = i2c_master_pkg::ST_AK_LO;
        end else if (stopSeqSet && ctrlOk) begin
          stopEn_nxt = 1'b1;
          sclLow_nxt = 1'b1;
          sdaLow_nxt = 1'b1;
          brgLoad    = 1'b1;
          state_nxt  = i2c_master_pkg::ST_SP_LO;
        end else if (rcvEnSet && ctrlOk && afterAck_r && rxInReady) begin
          rcvEn_nxt    = 1'b1;
          afterAck_nxt = 1'b0;
          sclLow_nxt   = 1'b1;
          sdaLow_nxt   = 1'b0;
          bitCnt_nxt   = i2c_master_pkg::BIT_FIRST;
          brgLoad      = 1'b1;
          state_nxt    = i2c_master_pkg::ST_RX_LO;
        end
      end
      i2c_master_pkg::ST_TX_LO: begin
        if (brgDone) begin
          sclLow_nxt = 1'b0;
          brgLoad    = 1'b1;
          state_nxt  = i2c_master_pkg::ST_TX_HI;
        end
      end
      i2c_master_pkg::ST_TX_HI: begin
        if (!sclIn) begin
          brgLoad = 1'b1;
        end else if (txLost) begin
          setBcl     = 1'b1;
          txFull_nxt = 1'b0;
          sdaLow_nxt = 1'b0;
          sclLow_nxt = 1'b0;
          state_nxt  = i2c_master_pkg::ST_IDLE;
        end else if (brgDone) begin
          sclLow_nxt = 1'b1;
          brgLoad    = 1'b1;
          if (bitCnt_r == i2c_master_pkg::BIT_ACK) begin
            ack_status_flag_nxt  = sdaIn;
            setInt       = 1'b1;
            afterAck_nxt = 1'b1;
            state_nxt    = i2c_master_pkg::ST_IDLE;
          end else begin
            if (bitCnt_r == i2c_master_pkg::BIT_LAST) begin
              txFull_nxt = 1'b0;
              sdaLow_nxt = 1'b0;
            end else begin
              sdaLow_nxt = !shift_r[6];
            end
            shift_nxt  = {shift_r[6:0], 1'b0};
            bitCnt_nxt = bitCnt_r + i2c_master_pkg::BIT_STEP;
            state_nxt  = i2c_master_pkg::ST_TX_LO;
          end
        end
      end
      i2c_master_pkg::ST_RX_LO: begin
        if (brgDone) begin
          sclLow_nxt = 1'b0;
          brgLoad    = 1'b1;
          state_nxt  = i2c_master_pkg::ST_RX_HI;
        end
      end
      i2c_master_pkg::ST_RX_HI: begin
        if (!sclIn) begin
          brgLoad = 1'b1;
        end else if (brgDone) begin
          shift_nxt  = rxByte;
          sclLow_nxt = 1'b1;
          brgLoad    = 1'b1;
          if (bitCnt_r == i2c_master_pkg::BIT_LAST) begin
            rxPush    = 1'b1;
            rcvEn_nxt = 1'b0;
            setInt    = 1'b1;
            setOv     = bufRdValid;
            state_nxt = i2c_master_pkg::ST_IDLE;
          end else begin
            bitCnt_nxt = bitCnt_r + i2c_master_pkg::BIT_STEP;
            state_nxt  = i2c_master_pkg::ST_RX_LO;
          end
        end
      end
      i2c_master_pkg::ST_AK_LO: begin
        if (brgDone) begin
          sclLow_nxt = 1'b0;
          brgLoad    = 1'b1;
          state_nxt  = i2c_master_pkg::ST_AK_HI;
        end
      end
      i2c_master_pkg::ST_AK_HI: begin
        if (!sclIn) begin
          brgLoad = 1'b1;
        end else if (akLost) begin
          setBcl     = 1'b1;
          ack_sequence_enable_nxt  = 1'b0;
          sdaLow_nxt = 1'b0;
          sclLow_nxt = 1'b0;
          state_nxt  = i2c_master_pkg::ST_IDLE;
        end else if (brgDone) begin
          sclLow_nxt   = 1'b1;
          ack_sequence_enable_nxt    = 1'b0;
          afterAck_nxt = 1'b1;
          state_nxt    = i2c_master_pkg::ST_IDLE;
        end
      end
      i2c_master_pkg::ST_SP_LO: begin
        if (sdaIn) begin
          brgLoad = 1'b1;
        end else if (brgDone) begin
          sclLow_nxt = 1'b0;
          brgLoad    = 1'b1;
          state_nxt  = i2c_master_pkg::ST_SP_CK;
        end
      end
      i2c_master_pkg::ST_SP_CK: begin
        if (!sclIn) begin
          brgLoad = 1'b1;
        end else if (brgDone) begin
          sdaLow_nxt = 1'b0;
          brgLoad    = 1'b1;
          state_nxt  = i2c_master_pkg::ST_SP_DA;
        end
      end
      i2c_master_pkg::ST_SP_DA: begin
        brgLoad = 1'b1;
        if (sdaIn && sclIn) begin
          state_nxt = i2c_master_pkg::ST_SP_END;
        end
      end
      i2c_master_pkg::ST_SP_END: begin
        if (brgDone) begin
          stopEn_nxt = 1'b0;
          setInt     = 1'b1;
          state_nxt  = i2c_master_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = i2c_master_pkg::ST_IDLE;
      end
    endcase
    // Disabling the module aborts whatever is under way
    if (!moduleEnable) begin
      state_nxt    = i2c_master_pkg::ST_IDLE;
      sdaLow_nxt   = 1'b0;
      sclLow_nxt   = 1'b0;
      txFull_nxt   = 1'b0;
      rcvEn_nxt    = 1'b0;
      ack_sequence_enable_nxt    = 1'b0;
      stopEn_nxt   = 1'b0;
      afterAck_nxt = 1'b0;
      rxPush       = 1'b0;
      setInt       = 1'b0;
    end
  end

  // Sequencer state and pin drive registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r  <= i2c_master_pkg::ST_IDLE;
      shift_r  <= i2c_master_pkg::SHIFT_RST;
      bitCnt_r <= i2c_master_pkg::BIT_FIRST;
      sdaLow_r <= i2c_master_pkg::FLAG_RST;
      sclLow_r <= i2c_master_pkg::FLAG_RST;
    end else begin
      state_r  <= state_nxt;
      shift_r  <= shift_nxt;
      bitCnt_r <= bitCnt_nxt;
      sdaLow_r <= sdaLow_nxt;
      sclLow_r <= sclLow_nxt;
    end
  end

  // Control bits and status captured by the sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txFull_r   <= i2c_master_pkg::FLAG_RST;
      afterAck_r <= i2c_master_pkg::FLAG_RST;
      ack_status_flag_r  <= i2c_master_pkg::FLAG_RST;
      rcvEn_r    <= i2c_master_pkg::FLAG_RST;
      ack_sequence_enable_r    <= i2c_master_pkg::FLAG_RST;
      stopEn_r   <= i2c_master_pkg::FLAG_RST;
    end else begin
      txFull_r   <= txFull_nxt;
      afterAck_r <= afterAck_nxt;
      ack_status_flag_r  <= ack_status_flag_nxt;
      rcvEn_r    <= rcvEn_nxt;
      ack_sequence_enable_r    <= ack_sequence_enable_nxt;
      stopEn_r   <= stopEn_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit period counter

  // Reloads from seven bits, counts down once per clock, rests at zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      brgCnt_r <= i2c_master_pkg::BRG_ZERO;
    end else if (brgLoad) begin
      brgCnt_r <= reloadValue;
    end else if (!brgDone) begin
      brgCnt_r <= brgCnt_r - i2c_master_pkg::BRG_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a set in the same cycle as a clear wins

  // Stop on a busy bus raises the port interrupt too when portIntEnable is set
  wire stopIrq = stopDet && startSeen_r && portIntEnable;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      write_collision_flag_r <= i2c_master_pkg::FLAG_RST;
      int_r  <= i2c_master_pkg::FLAG_RST;
      ov_r   <= i2c_master_pkg::FLAG_RST;
      bcl_r  <= i2c_master_pkg::FLAG_RST;
    end else begin
      write_collision_flag_r <= wrColl | (write_collision_flag_r & ~wcolClr);
      int_r  <= setInt | stopIrq | (int_r & ~intClr);
      ov_r   <= setOv | (ov_r & ~ovClr);
      bcl_r  <= setBcl | (bcl_r & ~bclClr);
    end
  end

  // Start and stop detection bits, cleared while disabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      startSeen_r <= i2c_master_pkg::FLAG_RST;
      stopSeen_r  <= i2c_master_pkg::FLAG_RST;
    end else if (!moduleEnable) begin
      startSeen_r <= 1'b0;
      stopSeen_r  <= 1'b0;
    end else if (stopDet) begin
      startSeen_r <= 1'b0;
      stopSeen_r  <= 1'b1;
    end else if (startDet) begin
      startSeen_r <= 1'b1;
      stopSeen_r  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer

  // Received bytes queue here; a pending CPU read loses nothing
  rx_buffer #(
    .WIDTH (i2c_master_pkg::DATA_W),
    .DEPTH (i2c_master_pkg::RX_DEPTH)
  ) u_rx_buffer (
    .clk      (clk),
    .arst_n   (arst_n),
    .inValid  (rxPush),
    .inReady  (rxInReady),
    .inData   (rxByte),
    .outValid (bufRdValid),
    .outReady (bufRead),
    .outData  (bufRdData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open-drain pins: only pull low or release
  assign sdaOut = 1'b0;
  assign sclOut = 1'b0;
  assign sdaOe  = sdaLow_r;
  assign sclOe  = sclLow_r;

  // Status view
  assign bufferFullFlag      = txFull_r | bufRdValid;
  assign writeCollisionFlag  = write_collision_flag_r;
  assign ackStatusFlag       = ack_status_flag_r;
  assign receiveEnableBit    = rcvEn_r;
  assign ackSequenceEnable   = ack_sequence_enable_r;
  assign stopSequenceEnable  = stopEn_r;
  assign portInterruptFlag   = int_r;
  assign receiveOverflowFlag = ov_r;
  assign busCollisionFlag    = bcl_r;
  assign startSeen           = startSeen_r;
  assign stopSeen            = stopSeen_r;
  assign busFree             = stopSeen_r | !startSeen_r;
  assign wakeUp              = sleepMode & portIntEnable & int_r;
  assign engineIdle          = isIdle;

endmodule

// >>> rtl/pin_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] pinAsync,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1_r;

  // First stage feeds only the second stage; pins idle high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_r <= '1;
      pinSync  <= '1;
    end else begin
      stage1_r <= pinAsync;
      pinSync  <= stage1_r;
    end
  end

endmodule

// >>> rtl/rx_buffer.sv
// Small FIFO holding received bytes between engine and CPU
`timescale 1ns/1ps
module rx_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W:0] CNT_ONE  = (PTR_W+1)'(1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH-1);
  localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wrPtr_r;
  logic [PTR_W-1:0] rdPtr_r;
  logic [PTR_W:0]   count_r;
  wire              push = inValid && inReady;
  wire              pop  = outValid && outReady;

  // Honest full and empty from the occupancy count
  assign inReady  = (count_r != CNT_FULL);
  assign outValid = (count_r != '0);
  assign outData  = mem_r[rdPtr_r];

  // Pointer and occupancy bookkeeping
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wrPtr_r <= (wrPtr_r == PTR_LAST) ? '0 : wrPtr_r + PTR_ONE;
      if (pop) rdPtr_r <= (rdPtr_r == PTR_LAST) ? '0 : rdPtr_r + PTR_ONE;
      if (push && !pop) count_r <= count_r + CNT_ONE;
      else if (pop && !push) count_r <= count_r - CNT_ONE;
    end
  end

  // Storage written at the write index
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
    end else if (push) begin
      mem_r[wrPtr_r] <= inData;
    end
  end

endmodule

// >>> testbench/i2c_master_byte_engine_sva.sv
// Port-level assertions for the I2C master byte engine
`timescale 1ns/1ps
module i2c_engine_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic moduleEnable,
  input wire logic repeatedStartBusy,
  input wire logic bufWrite,
  input wire logic engineIdle,
  input wire logic bufferFullFlag,
  input wire logic sclOe,
  input wire logic writeCollisionFlag,
  input wire logic ackSequenceEnable,
  input wire logic busCollisionFlag,
  input wire logic receiveEnableBit,
  input wire logic bufRdValid,
  input wire logic portInterruptFlag,
  input wire logic busFree,
  input wire logic stopSeen,
  input wire logic startSeen,
  input wire logic sdaOut,
  input wire logic sclOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // A write the idle engine takes; an acknowledge sequence that ends cleanly
  sequence wrTake;
    engineIdle && moduleEnable && !repeatedStartBusy && bufWrite;
  endsequence
  sequence ackDone;
    $fell(ackSequenceEnable) && moduleEnable && !busCollisionFlag;
  endsequence
  wr_start_a: assert property (wrTake |=> bufferFullFlag && !engineIdle)
    else $error("write did not start a byte");
  busy_wr_a: assert property (
    !engineIdle && moduleEnable && bufWrite |=> writeCollisionFlag)
    else $error("write while busy kept");
  rs_wr_a: assert property (
    repeatedStartBusy && moduleEnable && bufWrite |=> writeCollisionFlag)
    else $error("write in repeated start kept");
  ack_end_a: assert property (ackDone |-> sclOe && engineIdle)
    else $error("ack sequence end wrong");
  rx_end_a: assert property (
    $fell(receiveEnableBit) && moduleEnable |-> bufRdValid && portInterruptFlag)
    else $error("receive end wrong");
  bus_free_a: assert property (busFree == (stopSeen || !startSeen))
    else $error("bus free wrong");
  dis_clr_a: assert property (!moduleEnable |=> !startSeen && !stopSeen)
    else $error("detections kept while disabled");
  open_drain_a: assert property (!sdaOut && !sclOut)
    else $error("pin driven high");
endmodule
////////////////////////////////////////////////////////////
bind i2c_master_byte_engine i2c_engine_checker chk (.*);

// >>> testbench/i2c_master_byte_engine_tb.sv
// Random and corner-case bench for the I2C master byte engine
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch %0t %h %h", $time, (a), (e)); end end
module i2c_master_byte_engine_tb;
  logic clk = 1'h0, arst_n = 1'h0, frameRst = 1'h0, rdMode = 1'h0, slaveAck = 1'h0;
  logic stretch = 1'h0, moduleEnable, sleepMode, portIntEnable, ackDataBit, repeatedStartBusy;
  logic sdaPin, sclPin, sdaOut, sdaOe, sclOut, sclOe, bufRdValid, bufferFullFlag, startSeen;
  logic writeCollisionFlag, ackStatusFlag, receiveEnableBit, ackSequenceEnable, stopSeen;
  logic stopSequenceEnable, portInterruptFlag, receiveOverflowFlag, busCollisionFlag;
  logic busFree, wakeUp, engineIdle;
  logic [8:0] req = 9'h000, cap;
  logic [7:0] bufWrData, bufRdData, txByte, d;
  logic [7:0] s [2];
  logic [6:0] reloadValue;
  int checks = 0, bad_count = 0;
  // Clock and SDA capture at every SCL rise
  always #5 clk = ~clk;
  always @(posedge sclPin) cap <= {cap[7:0], sdaPin};
  // Request pulses come from req; everything else by matching name
  i2c_master_byte_engine uut (.bufWrite(req[0]), .ackSeqSet(req[1]), .stopSeqSet(req[2]),
    .rcvEnSet(req[3]), .wcolClr(req[4]), .ovClr(req[5]), .intClr(req[6]), .bclClr(req[7]),
    .bufRead(req[8]), .*);
  i2c_slave_model peer (.*);
  ////////////////////////////////////////////////////////////
  // Nine SDA levels expected at the rises of one sent byte
  function automatic logic [8:0] expCap(input logic [7:0] b, input logic ack);
    return {b, ~ack};
  endfunction
  // Counts, verdict and end of run
  task automatic print_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One-cycle request pulse
  task automatic pulse(input int b);
    @(negedge clk) req[b] = 1'h1;
    @(negedge clk) req[b] = 1'h0;
  endtask
  // Bounded wait for idle
  task automatic waitIdle;
    int n;
    for (n = 0; n < 3000 && engineIdle !== 1'h1; n++) @(negedge clk);
    if (n == 3000) begin
      bad_count++;
      print_verdict;
    end
  endtask
  // Arm the peer, issue a request, refuse a second write while sending
  task automatic run(input int b, input logic rd, input logic [7:0] sb);
    rdMode = rd;
    txByte = sb;
    cap = 9'h000;
    frameRst = 1'h1;
    @(negedge clk) frameRst = 1'h0;
    pulse(b);
    if (b == 0) begin
      repeat (3) @(negedge clk);
      bufWrData = ~bufWrData;
      pulse(0);
    end
    waitIdle;
  endtask
  // Main sequence
  initial begin
    void'($urandom(93));
    {moduleEnable, sleepMode, portIntEnable, ackDataBit, repeatedStartBusy} = 5'h1C;
    bufWrData = 8'h00;
    reloadValue = 7'h02;
    repeat (10) @(negedge clk);
    arst_n = 1'h1;
    `CHK({busFree, engineIdle, bufferFullFlag, portInterruptFlag, stopSeen}, 5'h18);
    pulse(3);
    `CHK(receiveEnableBit, 1'h0);
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      slaveAck = (i != 1);
      stretch = (i == 2);
      reloadValue = 7'($urandom_range(4, 1));
      bufWrData = d;
      run(0, 1'h0, 8'h00);
      `CHK(cap, expCap(d, slaveAck));
      `CHK(ackStatusFlag, ~slaveAck);
      `CHK({portInterruptFlag, sclOe}, 2'h3);
      `CHK(bufferFullFlag, 1'h0);
      `CHK(writeCollisionFlag, 1'h1);
      pulse(4);
      pulse(6);
      `CHK({writeCollisionFlag, portInterruptFlag}, 2'h0);
    end
    stretch = 1'h0;
    for (int j = 0; j < 2; j++) begin
      s[j] = 8'($urandom);
      run(3, 1'h1, s[j]);
      `CHK({bufRdValid, receiveEnableBit, portInterruptFlag}, 3'h5);
      `CHK(bufRdData, s[0]);
      `CHK(wakeUp, 1'h1);
      pulse(6);
      ackDataBit = j[0];
      run(1, 1'h0, 8'h00);
      `CHK({cap[0], ackSequenceEnable}, {ackDataBit, 1'h0});
    end
    `CHK(receiveOverflowFlag, 1'h1);
    pulse(8);
    `CHK(bufRdData, s[1]);
    pulse(8);
    `CHK(bufferFullFlag, 1'h0);
    run(2, 1'h0, 8'h00);
    `CHK({stopSeen, busFree, portInterruptFlag}, 3'h7);
    `CHK({sdaPin, sclPin, stopSequenceEnable}, 3'h6);
    // Peer holds SDA low under released ones: arbitration lost
    bufWrData = 8'hFF;
    run(0, 1'h1, 8'h00);
    rdMode = 1'h0;
    `CHK({busCollisionFlag, bufferFullFlag}, 2'h2);
    pulse(7);
    `CHK(busCollisionFlag, 1'h0);
    // Pending repeated start: writes collide, control sets dropped
    pulse(4);
    repeatedStartBusy = 1'h1;
    pulse(0);
    `CHK(writeCollisionFlag, 1'h1);
    pulse(2);
    `CHK(stopSequenceEnable, 1'h0);
    repeatedStartBusy = 1'h0;
    moduleEnable = 1'h0;
    repeat (2) @(negedge clk);
    `CHK({startSeen, stopSeen, sclOe, sdaOe}, 4'h0);
    print_verdict;
  end
endmodule

// >>> testbench/i2c_slave_model.sv
// Behavioural I2C slave with pull-ups: acknowledges, sends bytes, stretches SCL
`timescale 1ns/1ps
module i2c_slave_model (
  input wire logic clk,
  input wire logic frameRst,
  input wire logic rdMode,
  input wire logic slaveAck,
  input wire logic stretch,
  input wire logic [7:0] txByte,
  input wire logic sdaOe,
  input wire logic sclOe,
  output logic sdaPin,
  output logic sclPin
);
  logic [3:0] rises = 4'h0;
  logic [3:0] bitIdx = 4'h0;
  logic [2:0] lowCnt = 3'h0;
  // Bit index moves on at the fall after each rise
  always @(posedge sclPin or posedge frameRst) rises <= frameRst ? 4'h0 : rises + 4'h1;
  always @(negedge sclPin or posedge frameRst) bitIdx <= frameRst ? 4'h0 : rises;
  // Cycles since the master let go of SCL
  always @(posedge clk) lowCnt <= sclOe ? 3'h0 : lowCnt + {2'h0, lowCnt != 3'h6};
  // Released lines float high; SDA changes only while SCL is low
  assign sdaPin = !(sdaOe || (rdMode ? bitIdx < 4'h8 && !txByte[3'h7 - bitIdx[2:0]]
                                     : bitIdx == 4'h8 && slaveAck));
  assign sclPin = !(sclOe || (stretch && lowCnt != 3'h6));
endmodule
